// file: logic/plm_lane_status.v
// Receive status top: remote fault level, per-lane sync flags and lane map, register port and interrupt.
//
// Behaviour
// - The remote fault output is high while a remote fault is detected on the receive path and low otherwise.
// - The remote fault output is a level that holds for as long as the condition lasts.
// - Each physical lane presents a five-bit number of the logical lane received on it.
// - Twenty independent lane number fields exist, indexed by physical lane from zero.
// - A lane number field is valid only while that lane's sync flag is 1, and observers ignore it otherwise.
// - The lane number fields are levels that continuously follow the current lane mapping.
// - A lane's sync flag is 1 only once the lane has block lock and has received a lane marker.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`include "plm_defines.vh"

module plm_lane_status #(
    parameter NUM_LANES = `PLM_NUM_LANES,
    parameter ID_W = `PLM_ID_W
) (
    input wire clk,
    input wire reset_n,
    input wire remoteFaultIn,
    input wire [NUM_LANES-1:0] laneBlockLock,
    input wire [NUM_LANES-1:0] laneMarkerValid,
    input wire [NUM_LANES*ID_W-1:0] laneMarkerId,
    output reg remoteFault,
    output wire [NUM_LANES-1:0] laneSynced,
    output wire [NUM_LANES*ID_W-1:0] laneNumber,
    input wire [`PLM_ADDR_W-1:0] regAddr,
    input wire [31:0] regWriteData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regReadData,
    output wire irq
);

    // ------------------------------------------------------------
    // Lane trackers
    // ------------------------------------------------------------
    reg resyncCtrl;
    reg resyncPulse;
    wire allSynced;

    // Each lane keeps its own flag and number, so a lane that loses lock leaves the others alone.
    // A resync write reaches every lane in the same cycle.
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g = g + 1) begin : lane
            plm_lane_tracker #(
                .ID_W(ID_W)
            ) tracker (
                .clk(clk),
                .reset_n(reset_n),
                .resync(resyncPulse),
                .blockLock(laneBlockLock[g]),
                .markerValid(laneMarkerValid[g]),
                .markerLane(laneMarkerId[g*ID_W +: ID_W]),
                .synced(laneSynced[g]),
                .laneNumber(laneNumber[g*ID_W +: ID_W])
            );
        end
    endgenerate

    // Every lane must be synced at once; a single lane short keeps this low.
    assign allSynced = &laneSynced;

    // ------------------------------------------------------------
    // Remote fault level
    // ------------------------------------------------------------
    // No synchroniser: the fault condition comes from logic on this same clock.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            remoteFault <= 1'b0;
        end else begin
            // Followed every cycle, so the output stays high exactly as long as the condition.
            remoteFault <= remoteFaultIn;
        end
    end

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    reg prevFault;
    reg prevAllSynced;
    reg [NUM_LANES-1:0] prevSynced;
    wire [`PLM_IRQ_W-1:0] events;
    wire faultRose;
    wire faultFell;
    wire laneLost;
    wire allBecameSynced;

    // The previous values reset to the outputs' own reset levels, so no false edge follows reset.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prevFault <= 1'b0;
            prevAllSynced <= 1'b0;
            prevSynced <= {NUM_LANES{1'b0}};
        end else begin
            prevFault <= remoteFault;
            prevAllSynced <= allSynced;
            prevSynced <= laneSynced;
        end
    end

    // Edges are taken from the registered outputs, so an event is flagged in the cycle the output moves and its status bit sets on the next edge.
    assign faultRose = remoteFault & ~prevFault;
    assign faultFell = ~remoteFault & prevFault;
    // A resync also counts as a loss, since software must then treat the lane numbers as stale.
    assign laneLost = |(prevSynced & ~laneSynced);
    assign allBecameSynced = allSynced & ~prevAllSynced;

    assign events[`PLM_IRQ_FAULT_SET] = faultRose;
    assign events[`PLM_IRQ_FAULT_CLR] = faultFell;
    assign events[`PLM_IRQ_SYNC_LOST] = laneLost;
    assign events[`PLM_IRQ_ALL_SYNCED] = allBecameSynced;

    // ------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------
    // Register map: every word is 32 bits wide and unused bits read as zero.
    // Offset 8'h00 holds the remote fault level in bit 0 and the all-lanes-synced level in bit 1, read only.
    // Offset 8'h04 holds the twenty lane sync flags in bits 19:0, read only.
    // Offset 8'h08 is interrupt status, cleared by writing ones: bit 0 fault rose, bit 1 fault fell,
    // bit 2 some lane lost sync, bit 3 every lane became synced.
    // Offset 8'h0c is the interrupt mask with the same layout, and it is zero after reset.
    // Offset 8'h10 is control, bit 0 resync, which reads back as last written.
    // Offsets 8'h20 to 8'h6c give lane n at 8'h20 plus four times n: bits 4:0 number, bit 5 sync flag.
    // Writes to read-only or unmapped offsets are dropped, and reads of unmapped offsets return zero.
    reg [`PLM_IRQ_W-1:0] irqStatus;
    reg [`PLM_IRQ_W-1:0] irqMask;
    wire [`PLM_IRQ_W-1:0] irqClear;
    wire writeIrqStatus;
    wire writeIrqMask;
    wire writeControl;
    wire laneHit;
    wire [`PLM_ADDR_W-1:0] laneOffset;
    wire [`PLM_ADDR_W-3:0] laneIndex;

    assign writeIrqStatus = regWrite && (regAddr == `PLM_REG_IRQ_STATUS);
    assign writeIrqMask = regWrite && (regAddr == `PLM_REG_IRQ_MASK);
    assign writeControl = regWrite && (regAddr == `PLM_REG_CONTROL);
    assign irqClear = writeIrqStatus ? regWriteData[`PLM_IRQ_W-1:0] : {`PLM_IRQ_W{1'b0}};

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= {`PLM_IRQ_W{1'b0}};
            irqMask <= `PLM_IRQ_MASK_RESET;
            resyncCtrl <= `PLM_CTRL_RESET;
            resyncPulse <= 1'b0;
        end else begin
            // A new event in the cycle of its clear stays set.
            irqStatus <= (irqStatus & ~irqClear) | events;
            resyncPulse <= 1'b0;
            if (writeIrqMask) begin
                irqMask <= regWriteData[`PLM_IRQ_W-1:0];
            end
            if (writeControl) begin
                resyncCtrl <= regWriteData[`PLM_CTRL_RESYNC];
                // A written one drops every lane's sync once; lanes then relock from fresh markers.
                resyncPulse <= regWriteData[`PLM_CTRL_RESYNC];
            end
        end
    end

    // A level: it stays high until software clears the status bit or masks it.
    assign irq = |(irqStatus & irqMask);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // The lane window is decoded from the offset; a misaligned offset inside it reads as unmapped.
    assign laneOffset = regAddr - `PLM_REG_LANE_BASE;
    assign laneIndex = laneOffset[`PLM_ADDR_W-1:2];
    assign laneHit = (regAddr >= `PLM_REG_LANE_BASE) && (regAddr <= `PLM_REG_LANE_LAST) &&
                     (regAddr[1:0] == 2'h0);

    reg [31:0] next_regReadData;
    // The loop is a twenty-way select; only the addressed lane drives the word.
    integer i;

    always @* begin
        next_regReadData = 32'h0;
        if (regRead) begin
            case (regAddr)
                `PLM_REG_STATUS: begin
                    next_regReadData[`PLM_STATUS_FAULT] = remoteFault;
                    next_regReadData[`PLM_STATUS_ALL_SYNCED] = allSynced;
                end
                `PLM_REG_SYNCED: begin
                    next_regReadData[NUM_LANES-1:0] = laneSynced;
                end
                `PLM_REG_IRQ_STATUS: begin
                    next_regReadData[`PLM_IRQ_W-1:0] = irqStatus;
                end
                `PLM_REG_IRQ_MASK: begin
                    next_regReadData[`PLM_IRQ_W-1:0] = irqMask;
                end
                `PLM_REG_CONTROL: begin
                    next_regReadData[`PLM_CTRL_RESYNC] = resyncCtrl;
                end
                default: begin
                    if (laneHit) begin
                        for (i = 0; i < NUM_LANES; i = i + 1) begin
                            if (laneIndex == i[`PLM_ADDR_W-3:0]) begin
                                // The sync bit travels with the number so software can tell a stale field.
                                next_regReadData[ID_W-1:0] = laneNumber[i*ID_W +: ID_W];
                                next_regReadData[`PLM_LANE_SYNC_BIT] = laneSynced[i];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Zero outside the cycle after a read, so a late sample sees nothing rather than an old word.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData <= 32'h0;
        end else begin
            regReadData <= next_regReadData;
        end
    end

endmodule

// file: logic/plm_defines.vh
// Register offsets, field positions and reset values for the lane map and fault status block.
`ifndef PLM_DEFINES_VH
`define PLM_DEFINES_VH

`define PLM_ADDR_W 8
`define PLM_NUM_LANES 20
`define PLM_ID_W 5
`define PLM_MAX_ID 5'h13

`define PLM_REG_STATUS 8'h00
`define PLM_REG_SYNCED 8'h04
`define PLM_REG_IRQ_STATUS 8'h08
`define PLM_REG_IRQ_MASK 8'h0c
`define PLM_REG_CONTROL 8'h10
`define PLM_REG_LANE_BASE 8'h20
`define PLM_REG_LANE_LAST 8'h6c

`define PLM_IRQ_W 4
`define PLM_IRQ_FAULT_SET 0
`define PLM_IRQ_FAULT_CLR 1
`define PLM_IRQ_SYNC_LOST 2
`define PLM_IRQ_ALL_SYNCED 3

`define PLM_CTRL_RESYNC 0
`define PLM_STATUS_FAULT 0
`define PLM_STATUS_ALL_SYNCED 1
`define PLM_LANE_SYNC_BIT 5

`define PLM_IRQ_MASK_RESET 4'h0
`define PLM_CTRL_RESET 1'h0

`endif

// file: logic/plm_lane_tracker.v
// Tracker for one physical receive lane: word sync flag and received logical lane number.
`include "plm_defines.vh"

module plm_lane_tracker #(
    parameter ID_W = `PLM_ID_W
) (
    input wire clk,
    input wire reset_n,
    input wire resync,
    input wire blockLock,
    input wire markerValid,
    input wire [ID_W-1:0] markerLane,
    output reg synced,
    output reg [ID_W-1:0] laneNumber
);

    wire markerInRange;

    assign markerInRange = (markerLane <= `PLM_MAX_ID);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            synced <= 1'b0;
            laneNumber <= {ID_W{1'b0}};
        end else if (resync || !blockLock) begin
            synced <= 1'b0;
        end else if (markerValid && markerInRange) begin
            // Sync needs both block lock and a lane marker; out of range identifiers are never taken.
            synced <= 1'b1;
            laneNumber <= markerLane;
        end
    end

endmodule

// file: testbench/plm_checker.sv
// Port checks for the lane status top.
module plm_checker (
    input wire clk,
    input wire reset_n,
    input wire remoteFaultIn,
    input wire [19:0] laneBlockLock,
    input wire [19:0] laneMarkerValid,
    input wire [99:0] laneMarkerId,
    input wire remoteFault,
    input wire [19:0] laneSynced,
    input wire [99:0] laneNumber,
    input wire [7:0] regAddr,
    input wire regRead,
    input wire [31:0] regReadData
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    function automatic logic badId(input logic [99:0] n, input logic [19:0] s);
        badId = 1'b0;
        for (int g = 0; g < 20; g++) badId |= s[g] && n[g*5+:5] > 5'h13;
    endfunction
    fault_copy_a: assert property ($past(reset_n) |-> remoteFault == $past(remoteFaultIn))
        else $error("fault copy");
    fault_hold_a: assert property ($past(reset_n) && $stable(remoteFaultIn) |=> $stable(remoteFault))
        else $error("fault hold");
    sync_cause_a: assert property ((laneSynced & ~$past(laneSynced) & ~$past(laneBlockLock & laneMarkerValid)) == 0)
        else $error("sync cause");
    sync_lock_a: assert property ((laneSynced & ~$past(laneBlockLock)) == 0)
        else $error("sync lock");
    id_range_a: assert property (!badId(laneNumber, laneSynced))
        else $error("id range");
    lane_first_a: assert property (laneBlockLock[0] && laneMarkerValid[0] && laneMarkerId[4:0] <= 5'h13
        |=> laneSynced[0] && laneNumber[4:0] == $past(laneMarkerId[4:0])) else $error("lane 0 map");
    lane_last_a: assert property (laneBlockLock[19] && laneMarkerValid[19] && laneMarkerId[99:95] <= 5'h13
        |=> laneSynced[19] && laneNumber[99:95] == $past(laneMarkerId[99:95])) else $error("lane 19 map");
    sync_read_a: assert property (regRead && regAddr == 8'h04 |=> regReadData[19:0] == $past(laneSynced))
        else $error("sync read");
    cover property (laneSynced == 20'hfffff);
    cover property ($rose(remoteFault));
    cover property (regRead ##1 regReadData != 0);
endmodule
bind plm_lane_status plm_checker i_chk (.clk, .reset_n, .remoteFaultIn, .laneBlockLock, .laneMarkerValid,
    .laneMarkerId, .remoteFault, .laneSynced, .laneNumber, .regAddr, .regRead, .regReadData);

// file: testbench/plm_monitor.sv
// Far-side user logic that keeps a lane map of synced lanes only.
module plm_monitor (
    input wire [19:0] laneSynced,
    input wire [99:0] laneNumber,
    output logic [99:0] mapSeen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Unsynced fields read as 5'h1f, never a legal id, so a stale number cannot pass as valid.
    always_comb for (int g = 0; g < 20; g++) mapSeen[g*5+:5] = laneSynced[g] ? laneNumber[g*5+:5] : 5'h1f;
endmodule

// file: testbench/plm_lane_status_tb.sv
// Self-checking bench for the lane status top.
module plm_lane_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset_n = 0, remoteFaultIn = 0, regWrite = 0, regRead = 0, remoteFault, irq, expFault;
    logic [19:0] laneBlockLock = 0, laneMarkerValid = 0, laneSynced;
    logic [99:0] laneMarkerId = 0, laneNumber, mapSeen;
    logic [7:0] regAddr = 0;
    logic [31:0] regWriteData = 0, regReadData, v;
    int num_errors = 0, n_compared = 0;
    int expSync[20] = '{default: 0}, expNum[20] = '{default: 0};
    always #50 clk = ~clk;
    plm_lane_status i_dut (.clk, .reset_n, .remoteFaultIn, .laneBlockLock, .laneMarkerValid, .laneMarkerId,
        .remoteFault, .laneSynced, .laneNumber, .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .irq);
    plm_monitor i_mon (.laneSynced, .laneNumber, .mapSeen);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #10 chk("regReadData", e, regReadData);
    endtask
    initial begin
        void'($urandom(32'h98cc6863));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h0c, 32'h0);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            for (int g = 0; g < 20; g++) begin
                if (!laneBlockLock[g]) expSync[g] = 0;
                else if (laneMarkerValid[g] && laneMarkerId[g*5+:5] <= 19) begin
                    expSync[g] = 1;
                    expNum[g] = laneMarkerId[g*5+:5];
                end
            end
            expFault = remoteFaultIn;
            // Ids run over 0..31, so refused ids 20..31 are mixed in.
            laneBlockLock <= i >= 370 ? '1 : 20'($urandom() | $urandom());
            laneMarkerValid <= i >= 398 ? '0 : 20'($urandom());
            laneMarkerId <= 100'({$urandom(), $urandom(), $urandom(), $urandom()});
            remoteFaultIn <= i < 390 && $urandom_range(1);
            #10 chk("remoteFault", expFault, remoteFault);
            for (int g = 0; g < 20; g++) begin
                chk("laneSynced", expSync[g], laneSynced[g]);
                chk("laneNumber", expSync[g] ? expNum[g] : 31, mapSeen[g*5+:5]);
            end
        end
        for (int g = 0; g < 20; g++) begin
            v[g] = expSync[g];
            rd(8'h20 + 8'(4 * g), {26'h0, 1'(expSync[g]), 5'(expNum[g])});
        end
        rd(8'h04, v & 32'hfffff);
        rd(8'h80, 32'h0);
        wr(8'h08, 32'hf);
        wr(8'h0c, 32'h1);
        remoteFaultIn <= 1'b1;
        repeat (5) @(posedge clk);
        #10 chk("irq", 1, irq);
        rd(8'h00, {30'h0, v[19:0] == 20'hfffff, 1'b1});
        rd(8'h08, 32'h1);
        wr(8'h08, 32'h1);
        #10 chk("irq", 0, irq);
        wr(8'h0c, 32'h0);
        remoteFaultIn <= 1'b0;
        repeat (5) @(posedge clk);
        #10 chk("irq", 0, irq);
        rd(8'h08, 32'h2);
        wr(8'h10, 32'h1);
        repeat (2) @(posedge clk);
        #10 chk("laneSynced", 0, laneSynced);
        rd(8'h08, {28'h0, 1'b0, |v[19:0], 2'b10});
        rd(8'h10, 32'h1);
        rd(8'h00, 32'h0);
        @(posedge clk);
        laneMarkerId <= '0;
        laneMarkerValid <= '1;
        @(posedge clk);
        laneMarkerValid <= '0;
        repeat (2) @(posedge clk);
        #10 chk("laneSynced", 32'hfffff, laneSynced);
        chk("laneNumber", 0, 32'(|laneNumber));
        rd(8'h08, {28'h0, 1'b1, |v[19:0], 2'b10});
        wr(8'h0c, 32'h8);
        #10 chk("irq", 1, irq);
        wr(8'h08, 32'hf);
        #10 chk("irq", 0, irq);
        test_done();
    end
    initial begin
        #1000000;
        num_errors++;
        test_done();
    end
endmodule
